// *** hdl/rcm_pkg.sv ***
package rcm_pkg;

  localparam int CHANNELS   = 8;
  localparam int INPUTS     = 4;
  localparam int SEL_W      = 2;
  localparam int MODE_W     = 2;

  // register offsets
  localparam logic [3:0] OFS_ON_CMD     = 4'h0;
  localparam logic [3:0] OFS_INPUT_MODE = 4'h1;
  localparam logic [3:0] OFS_SEL_LOW    = 4'h2;
  localparam logic [3:0] OFS_SEL_HIGH   = 4'h3;
  localparam logic [3:0] OFS_STATUS     = 4'h4;

  // reset values
  localparam logic [7:0]  ON_CMD_RESET     = 8'h00;
  localparam logic [7:0]  INPUT_MODE_RESET = 8'h00;
  localparam logic [15:0] SEL_RESET        = 16'h0000;

  // status bit positions
  localparam int ST_TER_BIT   = 0;
  localparam int ST_FS_BIT    = 1;
  localparam int ST_STBY_BIT  = 2;

  typedef enum logic [2:0] {
    RCM_IDLE      = 3'b001,
    RCM_STANDBY   = 3'b010,
    RCM_FAIL_SAFE = 3'b100
  } rcm_state_t;

endpackage : rcm_pkg

// *** hdl/rcm_relay_channel_mode_control.sv ***
`timescale 1ns/100ps
module rcm_relay_channel_mode_control #(
  parameter int CHANNELS = rcm_pkg::CHANNELS,
  parameter int INPUTS   = rcm_pkg::INPUTS
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        reset_n_pin,
  input  wire logic        fail_safe_request_pin,
  input  wire logic        control_input_one,
  input  wire logic        control_input_two,
  input  wire logic        control_input_three,
  input  wire logic        control_input_four,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  output logic             channel_output_one,
  output logic             channel_output_two,
  output logic             channel_output_three,
  output logic             channel_output_four,
  output logic             channel_output_five,
  output logic             channel_output_six,
  output logic             channel_output_seven,
  output logic             channel_output_eight,
  output logic             standby,
  output logic             fail_safe_active
);

  // routing is written for the fixed pin set, so refuse other sizes at elaboration
  if (CHANNELS != 8 || INPUTS != 4) begin : g_bad_size
    $error("rcm: only eight channels and four inputs are supported");
  end

  rcm_pkg::rcm_state_t state;
  rcm_pkg::rcm_state_t next_state;

  logic [7:0]  on_cmd;
  logic [7:0]  input_mode;
  logic [15:0] channel_input_select;
  logic        transmission_error_flag;
  logic [7:0]  channel_drive;

  // control inputs are pulled down on the pad, so open reads low
  wire  [3:0]  ctrl_in = {control_input_four, control_input_three,
                          control_input_two, control_input_one};

  wire         in_fail_safe = fail_safe_request_pin;
  wire         leaving_fs   = (state == rcm_pkg::RCM_FAIL_SAFE) && !fail_safe_request_pin;
  wire         clear_regs   = in_fail_safe || !reset_n_pin || leaving_fs;
  wire         wr_ok        = reg_write && !clear_regs;

  wire         wr_on    = wr_ok && (reg_addr == rcm_pkg::OFS_ON_CMD);
  wire         wr_mode  = wr_ok && (reg_addr == rcm_pkg::OFS_INPUT_MODE);
  wire         wr_sel_l = wr_ok && (reg_addr == rcm_pkg::OFS_SEL_LOW);
  wire         wr_sel_h = wr_ok && (reg_addr == rcm_pkg::OFS_SEL_HIGH);
  wire         rd_stat  = reg_read && (reg_addr == rcm_pkg::OFS_STATUS);
  // any access counts as a transfer; the flag is shown in that read then dropped
  wire         transfer = reg_read || reg_write;

  wire [15:0] status_word = {13'h0000,
                             state == rcm_pkg::RCM_STANDBY,
                             state == rcm_pkg::RCM_FAIL_SAFE,
                             transmission_error_flag};

  wire [15:0] rd_mux =
    (reg_addr == rcm_pkg::OFS_ON_CMD)     ? {8'h00, on_cmd} :
    (reg_addr == rcm_pkg::OFS_INPUT_MODE) ? {8'h00, input_mode} :
    (reg_addr == rcm_pkg::OFS_SEL_LOW)    ? {8'h00, channel_input_select[7:0]} :
    (reg_addr == rcm_pkg::OFS_SEL_HIGH)   ? {8'h00, channel_input_select[15:8]} :
    (reg_addr == rcm_pkg::OFS_STATUS)     ? status_word :
                                            16'h0000;

  always_comb begin
    next_state = state;
    unique case (state)
      rcm_pkg::RCM_IDLE: begin
        if (in_fail_safe) begin
          next_state = rcm_pkg::RCM_FAIL_SAFE;
        end else if (!reset_n_pin) begin
          next_state = rcm_pkg::RCM_STANDBY;
        end
      end
      rcm_pkg::RCM_STANDBY: begin
        if (in_fail_safe) begin
          next_state = rcm_pkg::RCM_FAIL_SAFE;
        end else if (reset_n_pin) begin
          next_state = rcm_pkg::RCM_IDLE;
        end
      end
      rcm_pkg::RCM_FAIL_SAFE: begin
        if (!in_fail_safe) begin
          next_state = reset_n_pin ? rcm_pkg::RCM_IDLE : rcm_pkg::RCM_STANDBY;
        end
      end
      default: begin
        next_state = rcm_pkg::RCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= rcm_pkg::RCM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      on_cmd               <= rcm_pkg::ON_CMD_RESET;
      input_mode           <= rcm_pkg::INPUT_MODE_RESET;
      channel_input_select <= rcm_pkg::SEL_RESET;
    end else if (clear_regs) begin
      on_cmd               <= rcm_pkg::ON_CMD_RESET;
      input_mode           <= rcm_pkg::INPUT_MODE_RESET;
      channel_input_select <= rcm_pkg::SEL_RESET;
    end else begin
      if (wr_on) begin
        on_cmd <= reg_wdata[7:0];
      end
      if (wr_mode) begin
        input_mode <= reg_wdata[7:0];
      end
      if (wr_sel_l) begin
        channel_input_select[7:0] <= reg_wdata[7:0];
      end
      if (wr_sel_h) begin
        channel_input_select[15:8] <= reg_wdata[7:0];
      end
    end
  end

  // set on exit wins over the clear by a transfer in the same cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      transmission_error_flag <= 1'b0;
    end else if (leaving_fs) begin
      transmission_error_flag <= 1'b1;
    end else if (transfer && !in_fail_safe) begin
      transmission_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rd_stat ? status_word : (reg_read ? rd_mux : 16'h0000);
    end
  end

  // combinational routing keeps input pwm edges unretimed
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_chan
      wire [1:0] sel    = channel_input_select[2*ch +: 2];
      wire       normal = input_mode[ch] ? ctrl_in[sel] : on_cmd[ch];
      if (ch < 4) begin : g_low
        assign channel_drive[ch] = (state == rcm_pkg::RCM_FAIL_SAFE) ? ctrl_in[ch] :
                                   (state == rcm_pkg::RCM_IDLE) ? normal : 1'b0;
      end else begin : g_high
        assign channel_drive[ch] = (state == rcm_pkg::RCM_IDLE) ? normal : 1'b0;
      end
    end
  endgenerate

  assign channel_output_one   = channel_drive[0];
  assign channel_output_two   = channel_drive[1];
  assign channel_output_three = channel_drive[2];
  assign channel_output_four  = channel_drive[3];
  assign channel_output_five  = channel_drive[4];
  assign channel_output_six   = channel_drive[5];
  assign channel_output_seven = channel_drive[6];
  assign channel_output_eight = channel_drive[7];
  assign standby              = (state == rcm_pkg::RCM_STANDBY);
  assign fail_safe_active     = (state == rcm_pkg::RCM_FAIL_SAFE);

endmodule : rcm_relay_channel_mode_control

// *** verification/rcm_mcu_model.sv ***
`timescale 1ns/100ps
module rcm_mcu_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] reg_rdata,
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_write,
  output logic             reg_read
);
  initial {reg_addr, reg_wdata, reg_write, reg_read} = '0;
  // idle edge after each strobe, so strobes never merge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    // read data stand only in the cycle after the strobe, so take them mid-cycle
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
endmodule : rcm_mcu_model

// *** verification/rcm_relay_channel_mode_control_sva.sv ***
`timescale 1ns/100ps
module rcm_relay_channel_mode_control_sva (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        reset_n_pin,
  input wire logic        fail_safe_request_pin,
  input wire logic        control_input_one, control_input_two, control_input_three, control_input_four,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic        channel_output_one, channel_output_two, channel_output_three, channel_output_four,
  input wire logic        channel_output_five, channel_output_six, channel_output_seven, channel_output_eight,
  input wire logic        standby,
  input wire logic        fail_safe_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire [7:0] ch = {channel_output_eight, channel_output_seven, channel_output_six, channel_output_five,
                   channel_output_four, channel_output_three, channel_output_two, channel_output_one};
  wire [3:0] cin = {control_input_four, control_input_three, control_input_two, control_input_one};
  wire       exit_c = fail_safe_active && !fail_safe_request_pin;
  AST_FS_ENTRY: assert property (fail_safe_request_pin |=> fail_safe_active)
    else $error("fail-safe not entered");
  AST_FS_ROUTE: assert property (fail_safe_active |-> ch == {4'h0, cin})
    else $error("fail-safe routing wrong");
  AST_STBY_ENTRY: assert property (!reset_n_pin && !fail_safe_request_pin |=> standby)
    else $error("standby not entered");
  AST_STBY_OFF: assert property (standby |-> ch == 8'h00)
    else $error("channel on in standby");
  AST_STBY_WAKE: assert property (standby && reset_n_pin && !fail_safe_request_pin |=> !standby)
    else $error("standby not left");
  AST_FS_EXIT: assert property (exit_c |=> !fail_safe_active && ch == 8'h00 && standby == !$past(reset_n_pin))
    else $error("fail-safe exit wrong");
  AST_TER: assert property (exit_c ##1 (reg_read && reg_addr == 4'h4) |=> reg_rdata[0])
    else $error("error flag missing after exit");
  AST_POR: assert property ($fell(reset) |-> ch == 8'h00 && !standby && !fail_safe_active)
    else $error("state after reset wrong");
endmodule : rcm_relay_channel_mode_control_sva
bind rcm_relay_channel_mode_control rcm_relay_channel_mode_control_sva rcm_sva_i (.*);

// *** verification/rcm_relay_channel_mode_control_tb.sv ***
`timescale 1ns/100ps
module rcm_relay_channel_mode_control_tb;
  logic        ref_clk, reset, rn, fs, wr_s, rd_s, stby, fsa;
  logic [3:0]  inp, addr;
  logic [15:0] wdata, rdata;
  logic [7:0]  ch;
  int          error_cnt, tests_run, cyc;
  rcm_relay_channel_mode_control rcm_relay_channel_mode_control_i (
    .ref_clk(ref_clk), .reset(reset), .reset_n_pin(rn), .fail_safe_request_pin(fs),
    .control_input_one(inp[0]), .control_input_two(inp[1]),
    .control_input_three(inp[2]), .control_input_four(inp[3]),
    .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata),
    .channel_output_one(ch[0]), .channel_output_two(ch[1]), .channel_output_three(ch[2]),
    .channel_output_four(ch[3]), .channel_output_five(ch[4]), .channel_output_six(ch[5]),
    .channel_output_seven(ch[6]), .channel_output_eight(ch[7]), .standby(stby), .fail_safe_active(fsa));
  rcm_mcu_model m (.ref_clk(ref_clk), .reg_rdata(rdata), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // outputs checked on the falling edge, away from the launching edge
  task automatic co(input logic [7:0] e);
    @(negedge ref_clk);
    chk({8'h00, ch}, {8'h00, e});
  endtask : co
  task automatic rc(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    m.rd(a, d);
    chk(d, e);
  endtask : rc
  task automatic pins(input logic f, input logic r, input logic [3:0] i);
    @(posedge ref_clk);
    fs  <= f;
    rn  <= r;
    inp <= i;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : pins
  task automatic tally_and_finish;
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    reset = 1'b1;
    rn    = 1'b1;
    fs    = 1'b0;
    inp   = 4'h0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    co(8'h00);
    rc(rcm_pkg::OFS_ON_CMD, 16'h0000);
    m.wr(rcm_pkg::OFS_ON_CMD, 16'h00A5);
    co(8'hA5);
    m.wr(rcm_pkg::OFS_SEL_LOW, 16'h000B);
    m.wr(rcm_pkg::OFS_INPUT_MODE, 16'h0003);
    rc(rcm_pkg::OFS_INPUT_MODE, 16'h0003);
    rc(rcm_pkg::OFS_SEL_LOW, 16'h000B);
    pins(1'b0, 1'b1, 4'h4);
    co(8'hA6);
    pins(1'b0, 1'b1, 4'h0);
    co(8'hA4);
    pins(1'b1, 1'b1, 4'h5);
    co(8'h05);
    m.wr(rcm_pkg::OFS_ON_CMD, 16'h00FF);
    co(8'h05);
    rc(rcm_pkg::OFS_ON_CMD, 16'h0000);
    rc(rcm_pkg::OFS_STATUS, 16'h0002);
    chk({15'h0000, fsa}, 16'h0001);
    co(8'h05);
    pins(1'b0, 1'b1, 4'h5);
    co(8'h00);
    rc(rcm_pkg::OFS_STATUS, 16'h0001);
    rc(rcm_pkg::OFS_STATUS, 16'h0000);
    rc(4'hF, 16'h0000);
    m.wr(rcm_pkg::OFS_ON_CMD, 16'h0081);
    pins(1'b0, 1'b0, 4'h0);
    co(8'h00);
    chk({15'h0000, stby}, 16'h0001);
    rc(rcm_pkg::OFS_STATUS, 16'h0004);
    pins(1'b1, 1'b0, 4'hF);
    co(8'h0F);
    pins(1'b0, 1'b0, 4'hF);
    chk({15'h0000, stby}, 16'h0001);
    pins(1'b0, 1'b1, 4'hF);
    co(8'h00);
    tally_and_finish();
  end
endmodule : rcm_relay_channel_mode_control_tb
